// [analog_bias_power_ctrl_regs.sv]
// Purpose: APB register bank for reference, mic supply, bias and power
// Assumes: Synchronous active-low reset, one 100 MHz clock
// Notes:   Zero-wait APB slave; pslverr on unmapped addresses
//
// How it works
// - Mid-rail soft-start rate in bits 4:3: off/fast/nominal/slow, reset 00.
// - Bits 2:1 pick divider off/50k/250k/5k, bit 0 the buffer, reset 0.
// - Mic insertion threshold in bits 5:4, four rising levels, reset 00.
// - Mic short threshold sits in bits 3:2, four rising levels, reset 00.
// - Mic bit 1 enables detection and bit 0 the supply, both reset off.
// - DAC bit 5 doubles both DAC bias and mid-rail buffer bias, reset 0.
// - DAC bits 4:3 scale DAC bias normal, half, two thirds, three quarters.
// - DAC bits 2:1 scale the mid-rail buffer bias the same way, reset 00.
// - ADC bit 0 picks 64x (0) or 128x (1) oversampling, reset 1.
// - Power bits 1 and 0 enable left and right input amps, reset off.
// - Power bits 1 and 0 enable left and right output mixers, reset off.
// - Power bits 1 and 0 enable left and right headphones, reset off.
// - Clock family mode 10 means the 250 x fs clock family.
// - Any aligned write to index zero returns every register to its default.
`timescale 1ns/10ps
`default_nettype none
module analog_bias_power_ctrl_regs #(
   parameter logic [15:0] IDENT_CODE = 16'h5a5a // Arbitrary value
) (
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [7:0]                 paddr,
   input  wire logic [31:0]                pwdata,
   input  wire logic [3:0]                 pstrb,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   output bias_power_pkg::analog_ctrl_s    analog_ctrl,
   output logic                            osr_unsupported
);

   logic [15:0] midrail_control;
   logic [15:0] mic_supply_control;
   logic [15:0] dac_analog_bias;
   logic [15:0] adc_analog_oversample;
   logic [15:0] input_amp_power;
   logic [15:0] output_mixer_power;
   logic [15:0] headphone_output_power;
   logic [15:0] sysclk_family_mode;
   logic [15:0] wdata16;
   logic [5:0]  index;
   logic        access;
   logic        wr_en;
   logic        mapped;
   logic        soft_reset;
   logic [15:0] next_rdata;
   logic [4:0]  dac_scale;
   logic [4:0]  midbuf_scale;

   function automatic logic [15:0] merge(input logic [15:0] old_val,
                                         input logic [15:0] new_val,
                                         input logic [1:0]  strb,
                                         input logic [15:0] mask);
      logic [15:0] lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      merge = (old_val & ~lanes) | (new_val & lanes);
   endfunction

   function automatic logic is_mapped(input logic [5:0] idx);
      case (idx)
         bias_power_pkg::IDX_SOFT_RESET,
         bias_power_pkg::IDX_MIDRAIL,
         bias_power_pkg::IDX_MIC_SUPPLY,
         bias_power_pkg::IDX_DAC_BIAS,
         bias_power_pkg::IDX_ADC_OSR,
         bias_power_pkg::IDX_INPUT_AMP,
         bias_power_pkg::IDX_OUT_MIXER,
         bias_power_pkg::IDX_HEADPHONE,
         bias_power_pkg::IDX_SYSCLK: is_mapped = 1'b1;
         default:                    is_mapped = 1'b0;
      endcase
   endfunction

   assign index      = paddr[7:2];
   assign wdata16    = pwdata[15:0];
   assign access     = psel && penable;
   assign mapped     = is_mapped(index) && (paddr[1:0] == 2'h0);
   assign wr_en      = access && pwrite && mapped;
   assign soft_reset = wr_en && (index == bias_power_pkg::IDX_SOFT_RESET);
   assign pready     = 1'b1;
   assign pslverr    = access && !mapped;

   always_ff @(posedge core_clk) begin
      if (!rst_n || soft_reset) begin
         midrail_control <= bias_power_pkg::RST_ZERO;
      end else if (wr_en && index == bias_power_pkg::IDX_MIDRAIL) begin
         midrail_control <= merge(midrail_control, wdata16, pstrb[1:0],
                                  bias_power_pkg::MASK_MIDRAIL);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || soft_reset) begin
         mic_supply_control <= bias_power_pkg::RST_ZERO;
      end else if (wr_en && index == bias_power_pkg::IDX_MIC_SUPPLY) begin
         mic_supply_control <= merge(mic_supply_control, wdata16, pstrb[1:0],
                                     bias_power_pkg::MASK_MIC_SUPPLY);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || soft_reset) begin
         dac_analog_bias <= bias_power_pkg::RST_ZERO;
      end else if (wr_en && index == bias_power_pkg::IDX_DAC_BIAS) begin
         dac_analog_bias <= merge(dac_analog_bias, wdata16, pstrb[1:0],
                                  bias_power_pkg::MASK_DAC_BIAS);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || soft_reset) begin
         adc_analog_oversample <= bias_power_pkg::RST_ADC_OSR;
      end else if (wr_en && index == bias_power_pkg::IDX_ADC_OSR) begin
         adc_analog_oversample <= merge(adc_analog_oversample, wdata16,
                                        pstrb[1:0],
                                        bias_power_pkg::MASK_ADC_OSR);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || soft_reset) begin
         input_amp_power <= bias_power_pkg::RST_ZERO;
      end else if (wr_en && index == bias_power_pkg::IDX_INPUT_AMP) begin
         input_amp_power <= merge(input_amp_power, wdata16, pstrb[1:0],
                                  bias_power_pkg::MASK_PAIR);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || soft_reset) begin
         output_mixer_power <= bias_power_pkg::RST_ZERO;
      end else if (wr_en && index == bias_power_pkg::IDX_OUT_MIXER) begin
         output_mixer_power <= merge(output_mixer_power, wdata16, pstrb[1:0],
                                     bias_power_pkg::MASK_PAIR);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || soft_reset) begin
         headphone_output_power <= bias_power_pkg::RST_ZERO;
      end else if (wr_en && index == bias_power_pkg::IDX_HEADPHONE) begin
         headphone_output_power <= merge(headphone_output_power, wdata16,
                                         pstrb[1:0],
                                         bias_power_pkg::MASK_PAIR);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || soft_reset) begin
         sysclk_family_mode <= bias_power_pkg::RST_ZERO;
      end else if (wr_en && index == bias_power_pkg::IDX_SYSCLK) begin
         sysclk_family_mode <= merge(sysclk_family_mode, wdata16, pstrb[1:0],
                                     bias_power_pkg::MASK_SYSCLK);
      end
   end

   // Read mux
   always_comb begin
      case (index)
         bias_power_pkg::IDX_SOFT_RESET: next_rdata = IDENT_CODE;
         bias_power_pkg::IDX_MIDRAIL:    next_rdata = midrail_control;
         bias_power_pkg::IDX_MIC_SUPPLY: next_rdata = mic_supply_control;
         bias_power_pkg::IDX_DAC_BIAS:   next_rdata = dac_analog_bias;
         bias_power_pkg::IDX_ADC_OSR:    next_rdata = adc_analog_oversample;
         bias_power_pkg::IDX_INPUT_AMP:  next_rdata = input_amp_power;
         bias_power_pkg::IDX_OUT_MIXER:  next_rdata = output_mixer_power;
         bias_power_pkg::IDX_HEADPHONE:  next_rdata = headphone_output_power;
         bias_power_pkg::IDX_SYSCLK:     next_rdata = sysclk_family_mode;
         default:                        next_rdata = 16'h0000;
      endcase
      if (!mapped) begin
         next_rdata = 16'h0000;
      end
   end

   // Read data in the access cycle, upper half reads zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= {16'h0000, next_rdata};
      end
   end

   bias_scale_decode dac_bias_dec (
      .boost  (dac_analog_bias[bias_power_pkg::DAC_BOOST_BIT]),
      .select (dac_analog_bias[bias_power_pkg::DAC_CUR_LSB +: 2]),
      .scale  (dac_scale)
   );

   bias_scale_decode midbuf_bias_dec (
      .boost  (dac_analog_bias[bias_power_pkg::DAC_BOOST_BIT]),
      .select (dac_analog_bias[bias_power_pkg::DAC_MID_LSB +: 2]),
      .scale  (midbuf_scale)
   );

   // Registered analog controls
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         analog_ctrl <= '0;
         analog_ctrl.midrail_softstart_rate <= bias_power_pkg::SOFT_OFF;
         analog_ctrl.midrail_divider_select <= bias_power_pkg::DIV_OFF;
         analog_ctrl.dac_current_scale      <= 5'h0c;
         analog_ctrl.dac_midbuf_scale       <= 5'h0c;
         analog_ctrl.adc_high_oversample    <= 1'b1;
      end else begin
         analog_ctrl.midrail_softstart_rate <= bias_power_pkg::softstart_e'(
            midrail_control[bias_power_pkg::MID_SOFT_LSB +: 2]);
         analog_ctrl.midrail_divider_select <= bias_power_pkg::divider_e'(
            midrail_control[bias_power_pkg::MID_DIV_LSB +: 2]);
         analog_ctrl.midrail_reference_on <=
            (midrail_control[bias_power_pkg::MID_DIV_LSB +: 2] != 2'h0);
         analog_ctrl.midrail_buffer_on <=
            midrail_control[bias_power_pkg::MID_BUF_BIT];
         analog_ctrl.mic_insert_threshold <=
            mic_supply_control[bias_power_pkg::MIC_INS_LSB +: 2];
         analog_ctrl.mic_short_threshold <=
            mic_supply_control[bias_power_pkg::MIC_SHORT_LSB +: 2];
         analog_ctrl.mic_detect_on <=
            mic_supply_control[bias_power_pkg::MIC_DET_BIT];
         analog_ctrl.mic_supply_on <=
            mic_supply_control[bias_power_pkg::MIC_SUP_BIT];
         analog_ctrl.dac_current_scale <= dac_scale;
         analog_ctrl.dac_midbuf_scale  <= midbuf_scale;
         analog_ctrl.adc_high_oversample <=
            adc_analog_oversample[bias_power_pkg::ADC_OSR_BIT];
         analog_ctrl.left_input_amp_on <=
            input_amp_power[bias_power_pkg::LEFT_BIT];
         analog_ctrl.right_input_amp_on <=
            input_amp_power[bias_power_pkg::RIGHT_BIT];
         analog_ctrl.left_out_mixer_on <=
            output_mixer_power[bias_power_pkg::LEFT_BIT];
         analog_ctrl.right_out_mixer_on <=
            output_mixer_power[bias_power_pkg::RIGHT_BIT];
         analog_ctrl.left_headphone_on <=
            headphone_output_power[bias_power_pkg::LEFT_BIT];
         analog_ctrl.right_headphone_on <=
            headphone_output_power[bias_power_pkg::RIGHT_BIT];
      end
   end

   // Flags low-power oversampling under the 250 x fs clock family
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         osr_unsupported <= 1'b0;
      end else begin
         osr_unsupported <= (sysclk_family_mode[1:0] ==
                             bias_power_pkg::SYSCLK_FAMILY_250) &&
                            !adc_analog_oversample[0];
      end
   end

endmodule // analog_bias_power_ctrl_regs
`default_nettype wire

// [bias_power_pkg.sv]
// Purpose: Shared constants and carriers for the bias and power bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are register indices; byte address is index times four
package bias_power_pkg;

   localparam int          ADDR_W        = 8;
   localparam int          REG_W         = 16;

   // Register indices
   localparam logic [5:0] IDX_SOFT_RESET = 6'h00;
   localparam logic [5:0] IDX_MIDRAIL    = 6'h05;
   localparam logic [5:0] IDX_MIC_SUPPLY = 6'h06;
   localparam logic [5:0] IDX_DAC_BIAS   = 6'h08;
   localparam logic [5:0] IDX_ADC_OSR    = 6'h0a;
   localparam logic [5:0] IDX_INPUT_AMP  = 6'h0c;
   localparam logic [5:0] IDX_OUT_MIXER  = 6'h0d;
   localparam logic [5:0] IDX_HEADPHONE  = 6'h0e;
   localparam logic [5:0] IDX_SYSCLK     = 6'h15;

   // Writable bit masks
   localparam logic [15:0] MASK_MIDRAIL    = 16'h001f;
   localparam logic [15:0] MASK_MIC_SUPPLY = 16'h003f;
   localparam logic [15:0] MASK_DAC_BIAS   = 16'h003f;
   localparam logic [15:0] MASK_ADC_OSR    = 16'h0001;
   localparam logic [15:0] MASK_PAIR       = 16'h0003;
   localparam logic [15:0] MASK_SYSCLK     = 16'h0003;

   // Reset values
   localparam logic [15:0] RST_ZERO        = 16'h0000;
   localparam logic [15:0] RST_ADC_OSR     = 16'h0001;

   // Field positions
   localparam int MID_SOFT_LSB   = 3;
   localparam int MID_DIV_LSB    = 1;
   localparam int MID_BUF_BIT    = 0;
   localparam int MIC_INS_LSB    = 4;
   localparam int MIC_SHORT_LSB  = 2;
   localparam int MIC_DET_BIT    = 1;
   localparam int MIC_SUP_BIT    = 0;
   localparam int DAC_BOOST_BIT  = 5;
   localparam int DAC_CUR_LSB    = 3;
   localparam int DAC_MID_LSB    = 1;
   localparam int ADC_OSR_BIT    = 0;
   localparam int LEFT_BIT       = 1;
   localparam int RIGHT_BIT      = 0;

   // System clock family encoding of 250 x fs
   localparam logic [1:0] SYSCLK_FAMILY_250 = 2'h2;

   typedef enum logic [1:0] {
      SOFT_OFF,
      SOFT_FAST,
      SOFT_NOMINAL,
      SOFT_SLOW
   } softstart_e;

   typedef enum logic [1:0] {
      DIV_OFF,
      DIV_50K,
      DIV_250K,
      DIV_5K
   } divider_e;

   // Bias scale, in units of one twelfth of normal, times two with boost
   typedef logic [4:0] bias_scale_t;

   typedef struct packed {
      softstart_e  midrail_softstart_rate;
      divider_e    midrail_divider_select;
      logic        midrail_reference_on;
      logic        midrail_buffer_on;
      logic [1:0]  mic_insert_threshold;
      logic [1:0]  mic_short_threshold;
      logic        mic_detect_on;
      logic        mic_supply_on;
      bias_scale_t dac_current_scale;
      bias_scale_t dac_midbuf_scale;
      logic        adc_high_oversample;
      logic        left_input_amp_on;
      logic        right_input_amp_on;
      logic        left_out_mixer_on;
      logic        right_out_mixer_on;
      logic        left_headphone_on;
      logic        right_headphone_on;
   } analog_ctrl_s;

endpackage

// [bias_scale_decode.sv]
// Purpose: Turns a 2-bit bias select and boost into a scale in twelfths
// Assumes: Normal bias equals twelve
// Notes:   Boost doubles the selected scale
`timescale 1ns/10ps
`default_nettype none
module bias_scale_decode (
   input  wire logic                       boost,
   input  wire logic [1:0]                 select,
   output logic      [4:0]                 scale
);

   function automatic logic [4:0] base_scale(input logic [1:0] sel);
      case (sel)
         2'h0:    base_scale = 5'h0c;
         2'h1:    base_scale = 5'h06;
         2'h2:    base_scale = 5'h08;
         2'h3:    base_scale = 5'h09;
         default: base_scale = 5'h0c;
      endcase
   endfunction

   logic [4:0] base;

   always_comb begin
      base  = base_scale(select);
      scale = base;
      if (boost) begin
         scale = {base[3:0], 1'b0};
      end
   end

endmodule // bias_scale_decode
`default_nettype wire

// [bias_power_sva.sv]
// Purpose: Checker for the bias and power register bank
// Assumes: Sees only the bank's ports; writes land two edges later
// Notes:   Bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module bias_power_sva (
   input wire logic                         core_clk,
   input wire logic                         rst_n,
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pwrite,
   input wire logic [7:0]                   paddr,
   input wire logic [31:0]                  pwdata,
   input wire logic [3:0]                   pstrb,
   input wire logic [31:0]                  prdata,
   input wire logic                         pready,
   input wire logic                         pslverr,
   input wire bias_power_pkg::analog_ctrl_s analog_ctrl,
   input wire logic                         osr_unsupported
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   localparam logic [28:0] DEF = 29'h0000c640;
   logic        acc;
   logic        wr;
   logic [31:0] d1, d2;
   logic [7:0]  a1, a2;
   assign acc = psel && penable && pready;
   assign wr  = acc && pwrite && pstrb[0];
   always_ff @(posedge core_clk) begin
      d1 <= pwdata;
      d2 <= d1;
      a1 <= paddr;
      a2 <= a1;
   end
   function automatic logic [4:0] sc(input logic b, input logic [1:0] s);
      logic [4:0] v;
      case (s)
         2'h0:    v = 5'h0c;
         2'h1:    v = 5'h06;
         2'h2:    v = 5'h08;
         default: v = 5'h09;
      endcase
      return b ? {v[3:0], 1'b0} : v;
   endfunction
   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && a[7:2] inside
         {6'h00, 6'h05, 6'h06, 6'h08, 6'h0a, 6'h0c, 6'h0d, 6'h0e, 6'h15};
   endfunction
   a_midrail_fields: assert property (
      wr && paddr == 8'h14 |-> ##2
      analog_ctrl[28:23] == {d2[4:1], |d2[2:1], d2[0]}) else $error("midrail");
   a_mic_fields: assert property (
      wr && paddr == 8'h18 |-> ##2
      analog_ctrl[22:17] == d2[5:0]) else $error("mic fields");
   a_dac_scale: assert property (
      wr && paddr == 8'h20 |-> ##2
      analog_ctrl[16:12] == sc(d2[5], d2[4:3]) &&
      analog_ctrl[11:7] == sc(d2[5], d2[2:1])) else $error("dac scale");
   a_osr_high_ok: assert property (
      wr && paddr == 8'h28 && pwdata[0]
      |-> ##2 !osr_unsupported) else $error("osr flag");
   a_power_pairs: assert property (
      wr && paddr inside {8'h30, 8'h34, 8'h38}
      |-> ##2 (a2 == 8'h30 ? analog_ctrl[5:4] : a2 == 8'h34 ?
      analog_ctrl[3:2] : analog_ctrl[1:0]) == d2[1:0]) else $error("power");
   a_soft_default: assert property (
      acc && pwrite && paddr == 8'h00
      |-> ##2 analog_ctrl == DEF) else $error("soft reset");
   a_unmapped_err: assert property (
      acc && !mapped(paddr) |-> pslverr) else $error("no error");
   a_mapped_ok: assert property (
      acc && mapped(paddr) |-> !pslverr) else $error("bad error");
   a_unmapped_zero: assert property (
      acc && !pwrite && !mapped(paddr)
      |-> prdata == 32'h0) else $error("unmapped data");
   a_upper_zero: assert property (
      acc && !pwrite |-> prdata[31:16] == 16'h0) else $error("upper half");
   cover property (acc && pwrite && paddr == 8'h00);
   cover property (acc && pslverr);
   cover property ($rose(osr_unsupported));
endmodule // bias_power_sva
bind analog_bias_power_ctrl_regs bias_power_sva u_sva (.core_clk(core_clk),
   .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .analog_ctrl(analog_ctrl),
   .osr_unsupported(osr_unsupported));
`default_nettype wire

// [analog_bias_power_ctrl_regs_tb_top.sv]
// Purpose: Self-checking bench for the bias and power register bank
// Assumes: Zero-wait APB slave, registers at index times four
// Notes:   The bench drives APB itself
`timescale 1ns/10ps
`default_nettype none
module analog_bias_power_ctrl_regs_tb_top;
   localparam logic [15:0] IDENT = 16'h3c3c; // Arbitrary value
   localparam logic [28:0] DEF   = 29'h0000c640;
   localparam logic [4:0]  SC [4] = '{5'h0c, 5'h06, 5'h08, 5'h09};
   localparam logic [7:0]  RA [8] = '{8'h14, 8'h18, 8'h20, 8'h28,
                                      8'h30, 8'h34, 8'h38, 8'h54};
   localparam logic [7:0]  RM [8] = '{8'h1f, 8'h3f, 8'h3f, 8'h01,
                                      8'h03, 8'h03, 8'h03, 8'h03};
   logic                         core_clk, rst_n, psel, penable, pwrite;
   logic [7:0]                   paddr;
   logic [31:0]                  pwdata, prdata, rdat;
   logic [3:0]                   pstrb;
   logic                         pready, pslverr, osr_unsupported, rerr;
   bias_power_pkg::analog_ctrl_s analog_ctrl;
   int                           error_cnt, checked;
   logic [1:0]                   sv;
   logic                         bv;

   analog_bias_power_ctrl_regs #(.IDENT_CODE(IDENT)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .analog_ctrl(analog_ctrl), .osr_unsupported(osr_unsupported));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d,
                       input logic [3:0] s);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {~d, d};
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rdat = prdata;
      rerr = pslverr;
      if (n >= 16) error_cnt++;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic ee);
      xfer(a, 1'b0, 16'h0000, 4'h0);
      chk(rdat, {16'h0000, e});
      chk({31'h0, rerr}, {31'h0, ee});
   endtask

   task automatic settle();
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic defaults();
      for (int i = 0; i < 8; i++) begin
         rd(RA[i], {15'h0, i == 3}, 1'b0);
      end
      rd(8'h00, IDENT, 1'b0);
      settle();
      chk({3'h0, analog_ctrl}, {3'h0, DEF});
   endtask

   function automatic logic [4:0] es(input logic b, input logic [1:0] x);
      return b ? {SC[x][3:0], 1'b0} : SC[x];
   endfunction

   initial begin
      error_cnt = 0;
      checked = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      defaults();
      for (int i = 0; i < 8; i++) xfer(RA[i], 1'b1, 16'hffff, 4'hf);
      for (int i = 0; i < 8; i++) begin
         rd(RA[i], {8'h00, RM[i]}, 1'b0);
      end
      xfer(8'h18, 1'b1, 16'h0000, 4'h2);
      rd(8'h18, 16'h003f, 1'b0);
      xfer(8'h1c, 1'b1, 16'hffff, 4'hf);
      chk({31'h0, rerr}, 32'h1);
      rd(8'h1c, 16'h0000, 1'b1);
      rd(8'h15, 16'h0000, 1'b1);
      xfer(8'h00, 1'b1, 16'h1234, 4'hf);
      defaults();
      for (int k = 0; k < 8; k++) begin
         sv = k[1:0];
         bv = k[2];
         xfer(8'h14, 1'b1, {11'h0, sv, sv, sv[0]}, 4'hf);
         xfer(8'h18, 1'b1, {10'h0, sv, ~sv, sv}, 4'hf);
         xfer(8'h20, 1'b1, {10'h0, bv, sv, ~sv, 1'b0}, 4'hf);
         for (int p = 0; p < 3; p++) begin
            xfer(8'h30 + 8'(4 * p), 1'b1, {14'h0, sv}, 4'hf);
         end
         settle();
         chk(32'(analog_ctrl[28:23]),
             32'({sv, sv, |sv, sv[0]}));
         chk(32'(analog_ctrl[22:17]),
             32'({sv, ~sv, sv}));
         chk(32'(analog_ctrl[16:7]),
             32'({es(bv, sv), es(bv, ~sv)}));
         chk(32'(analog_ctrl[5:0]),
             32'({sv, sv, sv}));
      end
      xfer(8'h54, 1'b1, 16'h0002, 4'hf);
      xfer(8'h28, 1'b1, 16'h0000, 4'hf);
      settle();
      chk({31'h0, osr_unsupported}, 32'h1);
      chk({31'h0, analog_ctrl.adc_high_oversample}, 32'h0);
      xfer(8'h28, 1'b1, 16'h0001, 4'hf);
      settle();
      chk({31'h0, osr_unsupported}, 32'h0);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      defaults();
      results();
   end

   initial begin
      repeat (5000) @(posedge core_clk);
      error_cnt++;
      results();
   end
endmodule // analog_bias_power_ctrl_regs_tb_top
`default_nettype wire
